// ===== dac_audio_out.v
// Purpose: audio clock cleaner, master clock and serial audio output
// Assumes: recovered audio arrives from the link logic as pins; mclk_i 50 MHz
// Notes: the cleaner is a digital period tracker, not an analog loop
`timescale 1ns/1ps
`include "dac_map.vh"

// How it works
// - cleaner regenerates bit clock from averaged period
// - secondary data retimed to same bit clock
// - master clock is x1, x2 or x4
// - cleaner off forces master clock low
// - after reset master clock runs x2
// - rate code minus bit clock band gives multiplier
// - low red/green bits become four GPIOs
// - secondary on means 18-bit colour mode
// - audio from video frame or blanking packets
module dac_audio_out (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    input wire strap_sec_i,
    input wire frm_bclk_i,
    input wire frm_wclk_i,
    input wire frm_data_i,
    input wire frm_data_b_i,
    input wire pkt_bclk_i,
    input wire pkt_wclk_i,
    input wire pkt_data_i,
    input wire pkt_data_b_i,
    output reg bclk_o,
    output reg wclk_o,
    output reg data_o,
    output reg secondary_audio_data_o,
    output reg mclk_out_o,
    output wire mode18_o,
    input wire [3:0] vid_lo_i,
    input wire [3:0] fwd_gpio_i,
    input wire [3:0] color_lo_in_i,
    output reg [3:0] color_lo_o,
    output reg [3:0] color_lo_oe_o,
    output reg [3:0] back_gpio_o
);
    // ****************************************
    // input synchronisers
    // ****************************************
    wire [7:0] aud_s;
    wire [3:0] gpio_s;
    wire strap_s;

    dac_sync #(.W(8)) u_aud_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i({pkt_data_b_i, pkt_data_i, pkt_wclk_i, pkt_bclk_i,
                  frm_data_b_i, frm_data_i, frm_wclk_i, frm_bclk_i}),
        .sync_o(aud_s)
    );

    dac_sync #(.W(5)) u_pin_sync (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .async_i({strap_sec_i, color_lo_in_i}),
        .sync_o({strap_s, gpio_s})
    );

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] jit_r;
    reg [7:0] mck_r;
    reg strap_r;
    reg [1:0] strap_wait_r;
    reg locked_r;

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            jit_r <= `DAC_JIT_RST;
            mck_r <= `DAC_MCK_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `DAC_JIT_ADDR)
                jit_r <= reg_wdata_i & `DAC_JIT_WMASK;
            if (reg_addr_i == `DAC_MCK_ADDR)
                mck_r <= reg_wdata_i & `DAC_MCK_WMASK;
        end
    end

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `DAC_JIT_ADDR: reg_rdata_o <= jit_r | {4'h0, locked_r, 3'h0};
                `DAC_MCK_ADDR: reg_rdata_o <= mck_r;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // strap caught once, after the synchroniser has refilled from reset
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            strap_r <= 1'b0;
            strap_wait_r <= 2'h0;
        end else if (strap_wait_r != `DAC_STRAP_DONE) begin
            strap_wait_r <= strap_wait_r + 2'h1;
            if (strap_wait_r == `DAC_STRAP_WAIT)
                strap_r <= strap_s;
        end
    end

    wire clean_en = jit_r[`DAC_JIT_EN_BIT];
    assign mode18_o = strap_r | jit_r[`DAC_JIT_SEC_BIT];

    // ****************************************
    // source select and edge detect
    // ****************************************
    wire use_pkt = jit_r[`DAC_JIT_PKT_BIT];
    wire [3:0] src = use_pkt ? aud_s[7:4] : aud_s[3:0];
    reg bclk_d_r;
    wire rise = src[0] & ~bclk_d_r;
    wire fall = ~src[0] & bclk_d_r;

    // ****************************************
    // period tracker and regenerated bit clock
    // ****************************************
    reg [7:0] cnt_r;
    reg [7:0] avg_r;
    reg [7:0] ph_r;
    reg [2:0] good_r;
    reg [2:0] cap_r;
    wire [9:0] avg_sum = {2'b00, avg_r} + {1'b0, avg_r, 1'b0} + {2'b00, cnt_r};
    wire [7:0] half = {1'b0, avg_r[7:1]};
    wire ph_wrap = (ph_r >= avg_r - 8'h01);
    wire ph_off = (ph_r >= 8'h02) && (ph_r <= avg_r - 8'h02);

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bclk_d_r <= 1'b0;
            cnt_r <= 8'h00;
            avg_r <= 8'h00;
            ph_r <= 8'h00;
            good_r <= 3'h0;
            locked_r <= 1'b0;
            cap_r <= 3'h0;
        end else begin
            bclk_d_r <= src[0];
            if (rise) begin
                // count from one so a whole period is stored
                cnt_r <= 8'h01;
                cap_r <= src[3:1];
                if (good_r == `DAC_LOCK_CNT) begin
                    avg_r <= avg_sum[9:2];
                    locked_r <= 1'b1;
                end else begin
                    avg_r <= cnt_r;
                    good_r <= good_r + 3'h1;
                end
            end else if (cnt_r != `DAC_PER_MAX) begin
                cnt_r <= cnt_r + 8'h01;
            end else begin
                good_r <= 3'h0;
                locked_r <= 1'b0;
            end
            // phase pulled in on every rise until locked, then only when the error is large
            if (rise && (!locked_r || ph_off))
                ph_r <= 8'h00;
            else if (ph_wrap)
                ph_r <= 8'h00;
            else
                ph_r <= ph_r + 8'h01;
        end
    end

    wire clean_clk = locked_r && (ph_r < half);
    wire clean_fall = locked_r && (ph_r == half);

    // ****************************************
    // serial audio outputs
    // ****************************************
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bclk_o <= 1'b0;
            wclk_o <= 1'b0;
            data_o <= 1'b0;
            secondary_audio_data_o <= 1'b0;
        end else if (clean_en) begin
            bclk_o <= clean_clk;
            if (clean_fall) begin
                wclk_o <= cap_r[0];
                data_o <= cap_r[1];
            end
            // secondary line silenced at once when leaving 18-bit mode
            if (!mode18_o)
                secondary_audio_data_o <= 1'b0;
            else if (clean_fall)
                secondary_audio_data_o <= cap_r[2];
        end else begin
            bclk_o <= src[0];
            if (fall) begin
                wclk_o <= src[1];
                data_o <= src[2];
            end
            if (!mode18_o)
                secondary_audio_data_o <= 1'b0;
            else if (fall)
                secondary_audio_data_o <= src[3];
        end
    end

    // ****************************************
    // master clock multiplier
    // ****************************************
    reg [1:0] band;
    reg [1:0] mult;
    wire [2:0] code = mck_r[`DAC_MCK_CODE_MSB:`DAC_MCK_CODE_LSB];
    wire [2:0] diff = code - {1'b0, band};

    always @* begin
        if (avg_r >= `DAC_BAND0_MIN)
            band = 2'h0;
        else if (avg_r >= `DAC_BAND1_MIN)
            band = 2'h1;
        else if (avg_r >= `DAC_BAND2_MIN)
            band = 2'h2;
        else
            band = 2'h3;
        if (!mck_r[`DAC_MCK_OVR_BIT])
            mult = `DAC_MULT_DEF;
        else if (code < {1'b0, band})
            mult = 2'h0;
        else if (band == 2'h3 && code == `DAC_MCK_CODE_X4_TOP)
            mult = 2'h2;
        else if (diff >= 3'h2)
            mult = 2'h2;
        else
            mult = diff[1:0];
    end

    reg [7:0] mc_r;
    wire [7:0] mc_lim_raw = avg_r >> ({1'b0, mult} + 3'h1);
    wire [7:0] mc_lim = (mc_lim_raw == 8'h00) ? 8'h01 : mc_lim_raw;

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            mc_r <= 8'h00;
            mclk_out_o <= 1'b0;
        end else if (!clean_en || !locked_r) begin
            mc_r <= 8'h00;
            mclk_out_o <= 1'b0;
        end else if (ph_r == 8'h00) begin
            mc_r <= 8'h01;
            mclk_out_o <= 1'b1;
        end else if (mc_r >= mc_lim) begin
            mc_r <= 8'h01;
            mclk_out_o <= ~mclk_out_o;
        end else begin
            mc_r <= mc_r + 8'h01;
        end
    end

    // ****************************************
    // low colour bits or GPIO
    // ****************************************
    wire [3:0] gpio_dir = jit_r[7:`DAC_JIT_DIR_LSB];

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            color_lo_o <= 4'h0;
            color_lo_oe_o <= 4'h0;
            back_gpio_o <= 4'h0;
        end else if (mode18_o) begin
            color_lo_o <= fwd_gpio_i & ~gpio_dir;
            color_lo_oe_o <= ~gpio_dir;
            back_gpio_o <= gpio_s & gpio_dir;
        end else begin
            color_lo_o <= vid_lo_i;
            color_lo_oe_o <= 4'hF;
            back_gpio_o <= 4'h0;
        end
    end
endmodule

// ===== dac_chk_assertions.sv
// Purpose: port checks of the audio clock output block
// Assumes: one clock, synchronous active-low reset
// Notes: helpers mirror the register writes
`timescale 1ns/1ps
module dac_chk (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    input wire [3:0] fwd_gpio_i,
    input wire secondary_audio_data_o,
    input wire mclk_out_o,
    input wire mode18_o,
    input wire [3:0] color_lo_o,
    input wire [3:0] color_lo_oe_o
);
    reg [7:0] jit_r;
    reg [7:0] mck_r;
    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            jit_r <= 8'h01;
            mck_r <= 8'h00;
        end else begin
            jit_r <= (reg_wr_i && reg_addr_i == 8'h2B) ? reg_wdata_i : jit_r;
            mck_r <= (reg_wr_i && reg_addr_i == 8'h3A) ? (reg_wdata_i & 8'hF0) : mck_r;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_mck_off; !jit_r[0] [*3] |-> !mclk_out_o; endproperty
    a_mck_off: assert property (p_mck_off) else $error("master clock with cleaner off");
    property p_mode; jit_r[2] |-> mode18_o; endproperty
    a_mode: assert property (p_mode) else $error("mode bit not shown");
    property p_sec0; !mode18_o && $past(!mode18_o, 2) |-> !secondary_audio_data_o; endproperty
    a_sec0: assert property (p_sec0) else $error("secondary data in 24-bit mode");
    property p_oe24; !mode18_o && $past(!mode18_o, 2) && $past(rst_n_i) |-> color_lo_oe_o == 4'hF; endproperty
    a_oe24: assert property (p_oe24) else $error("colour pins not driven");
    property p_gpio;
        mode18_o && $past(mode18_o, 2) && $past(fwd_gpio_i) == fwd_gpio_i
        |-> (color_lo_o & color_lo_oe_o) == (fwd_gpio_i & color_lo_oe_o);
    endproperty
    a_gpio: assert property (p_gpio) else $error("forward gpio wrong");
    property p_rd_mck; reg_rd_i && reg_addr_i == 8'h3A |=> reg_rdata_o == $past(mck_r); endproperty
    a_rd_mck: assert property (p_rd_mck) else $error("rate reg read wrong");
    property p_rd_jit; reg_rd_i && reg_addr_i == 8'h2B |=> (reg_rdata_o & 8'hF7) == $past(jit_r & 8'hF7); endproperty
    a_rd_jit: assert property (p_rd_jit) else $error("jitter reg read wrong");
    property p_rd_un; reg_rd_i && reg_addr_i != 8'h2B && reg_addr_i != 8'h3A |=> reg_rdata_o == 8'h00; endproperty
    a_rd_un: assert property (p_rd_un) else $error("unmapped read not zero");
    c_mck: cover property ($rose(mclk_out_o));
    c_m18: cover property ($rose(mode18_o));
    c_off: cover property (!jit_r[0] ##1 !mclk_out_o);
endmodule
bind dac_audio_out dac_chk u_chk (
    .mclk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fwd_gpio_i,
    .secondary_audio_data_o, .mclk_out_o, .mode18_o, .color_lo_o, .color_lo_oe_o
);

// ===== dac_codec.sv
// Purpose: downstream codec model fed by the audio outputs
// Assumes: data sampled on rising bit clock
// Notes: counts master clock rises for rate checks
`timescale 1ns/1ps
module dac_codec (
    input wire bclk_i,
    input wire data_i,
    input wire sec_i,
    input wire mck_i,
    output reg [7:0] pri_o,
    output reg [7:0] sec_o,
    output reg [15:0] mck_n_o
);
    initial mck_n_o = 16'h0000;
    // both lines taken on the same bit clock edge
    always @(posedge bclk_i) begin
        pri_o <= {pri_o[6:0], data_i};
        sec_o <= {sec_o[6:0], sec_i};
    end
    always @(posedge mck_i) begin
        mck_n_o <= mck_n_o + 16'h0001;
    end
endmodule

// ===== dac_map.vh
// Purpose: constants of the audio clock output block
// Assumes: 8-bit register port, 50 MHz core clock
// Notes: definitions only
`ifndef DAC_MAP_VH
`define DAC_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define DAC_JIT_ADDR 8'h2B
`define DAC_MCK_ADDR 8'h3A

// ****************************************
// jitter control fields
// ****************************************
`define DAC_JIT_EN_BIT 0
`define DAC_JIT_PKT_BIT 1
`define DAC_JIT_SEC_BIT 2
`define DAC_JIT_LOCK_BIT 3
`define DAC_JIT_DIR_LSB 4
`define DAC_JIT_RST 8'h01
`define DAC_JIT_WMASK 8'hF7

// ****************************************
// master clock rate fields
// ****************************************
`define DAC_MCK_OVR_BIT 7
`define DAC_MCK_CODE_MSB 6
`define DAC_MCK_CODE_LSB 4
`define DAC_MCK_RST 8'h00
`define DAC_MCK_WMASK 8'hF0
`define DAC_MCK_CODE_X4_TOP 3'h6
`define DAC_MULT_DEF 2'h1

// ****************************************
// bit clock bands, period in core cycles
// ****************************************
`define DAC_CLK_MHZ 50
`define DAC_BAND0_MHZ 2
`define DAC_BAND1_MHZ 4
`define DAC_BAND2_MHZ 7
// core MHz over band MHz, sized to the period counter
`define DAC_BAND0_MIN 8'h19
`define DAC_BAND1_MIN 8'h0C
`define DAC_BAND2_MIN 8'h07
`define DAC_LOCK_CNT 3'h4
`define DAC_STRAP_WAIT 2'h2
`define DAC_STRAP_DONE 2'h3
`define DAC_PER_MAX 8'hFF

`endif

// ===== dac_sync.v
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to mclk_i
// Notes: only sync_o may be read by logic
`timescale 1ns/1ps
module dac_sync #(
    parameter W = 1
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            meta_r <= {W{1'b0}};
            sync_r <= {W{1'b0}};
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// ===== tb.sv
// Purpose: self-checking bench of the audio clock output block
// Assumes: 20 ns core clock, 160 ns bit clock
// Notes: codec model samples the outputs
`timescale 1ns/1ps
module tb;
    localparam [55:0] COD = 56'h0040A0B0C090F0;
    localparam [55:0] EXN = 56'h20201020401040;
    reg mclk, rst_n, wr_s, rd_s, run, dat, dtb;
    reg strap, wck;
    reg [7:0] addr, wdat;
    reg [3:0] fwd, pin, vid;
    reg [2:0] ph;
    wire bck = run & ph[2];
    wire bclk, wclk, data, sec, mck, m18;
    wire [7:0] rdata, pri, sco;
    wire [3:0] clo, coe, bgp;
    wire [15:0] mck_n;
    integer error_cnt, comparisons;
    dac_audio_out u_dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr_s),
        .reg_rd_i(rd_s), .reg_rdata_o(rdata), .strap_sec_i(strap), .frm_bclk_i(bck), .frm_wclk_i(wck),
        .frm_data_i(~dat), .frm_data_b_i(dtb), .pkt_bclk_i(bck), .pkt_wclk_i(wck), .pkt_data_i(dat),
        .pkt_data_b_i(dtb), .bclk_o(bclk), .wclk_o(wclk), .data_o(data), .secondary_audio_data_o(sec),
        .mclk_out_o(mck), .mode18_o(m18), .vid_lo_i(vid), .fwd_gpio_i(fwd), .color_lo_in_i(pin),
        .color_lo_o(clo), .color_lo_oe_o(coe), .back_gpio_o(bgp)
    );
    dac_codec u_cod (.bclk_i(bclk), .data_i(data), .sec_i(sec), .mck_i(mck), .pri_o(pri),
        .sec_o(sco), .mck_n_o(mck_n));
    always @(posedge mclk) #1 ph <= ph + 3'h1;
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task tick(input integer n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task complete_run;
        if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input string nm, input [7:0] e, input [7:0] s);
        comparisons = comparisons + 1;
        if (s !== e) begin
            $display("mismatch %s exp %h got %h", nm, e, s);
            error_cnt = error_cnt + 1;
        end
    endtask
    task chk_cnt(input string nm, input integer e, input integer s);
        comparisons = comparisons + 1;
        if (^s === 1'bx || s < e - e / 16 || s > e + e / 16) begin
            $display("mismatch %s exp %0d got %0d", nm, e, s);
            error_cnt = error_cnt + 1;
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        addr = a;
        wdat = d;
        wr_s = 1'b1;
        tick(1);
        wr_s = 1'b0;
        tick(1);
    endtask
    task rd(input [7:0] a, output [7:0] v);
        addr = a;
        rd_s = 1'b1;
        tick(1);
        rd_s = 1'b0;
        tick(1);
        v = rdata;
    endtask
    task meas(input integer e);
        integer c0;
        tick(16);
        c0 = mck_n;
        tick(128);
        chk_cnt("mclk rises", e, mck_n - c0);
    endtask
    task s_regs;
        reg [7:0] v;
        rd(8'h2B, v);
        chk("jitter reg", 8'h01, v);
        rd(8'h3A, v);
        chk("rate reg", 8'h00, v);
        chk("mode oe", 8'h0F, {m18, 3'h0, coe});
        wr(8'h3A, 8'h80);
        wr(8'h3A, 8'h8F);
        rd(8'h3A, v);
        chk("rate reg", 8'h80, v);
        wr(8'h55, 8'hFF);
        rd(8'h55, v);
        chk("unmapped", 8'h00, v);
        wr(8'h2B, 8'hFF);
        rd(8'h2B, v);
        chk("jitter reg", 8'hF7, v);
        wr(8'h2B, 8'h01);
        wr(8'h3A, 8'h00);
    endtask
    task s_mclk;
        reg [7:0] v;
        integer i;
        run = 1'b1;
        v = 8'h00;
        for (i = 0; i < 30 && v[3] !== 1'b1; i = i + 1) begin
            tick(4);
            rd(8'h2B, v);
        end
        chk("lock", 8'h01, {7'h00, v[3]});
        if (v[3] !== 1'b1) complete_run;
        for (i = 0; i < 7; i = i + 1) begin
            if (COD[55 - 8 * i]) wr(8'h3A, 8'h80);
            wr(8'h3A, COD[55 - 8 * i -: 8]);
            meas(EXN[55 - 8 * i -: 8]);
        end
        wr(8'h2B, 8'h00);
        meas(0);
    endtask
    task s_data;
        wck = 1'b1;
        wr(8'h2B, 8'h01);
        tick(96);
        chk("primary", 8'hFF, pri);
        chk("word clock", 8'h01, {7'h00, wclk});
        chk("secondary", 8'h00, sco);
        wr(8'h2B, 8'h05);
        tick(96);
        chk("secondary", 8'hFF, sco);
        chk("mode18", 8'h01, {7'h00, m18});
        wr(8'h2B, 8'h07);
        tick(96);
        chk("primary", 8'h00, pri);
    endtask
    task s_gpio;
        fwd = 4'hA;
        pin = 4'h6;
        tick(4);
        chk("gpio out", 8'hFA, {coe, clo});
        wr(8'h2B, 8'h55);
        tick(4);
        chk("gpio in", 8'hA4, {coe, bgp});
        chk("gpio mixed", 8'hAA, {coe, clo});
        vid = 4'h9;
        wr(8'h2B, 8'h01);
        tick(2);
        chk("mode oe", 8'h0F, {m18, 3'h0, coe});
        chk("video low", 8'hF9, {coe, clo});
    endtask
    task s_strap;
        strap = 1'b1;
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
        tick(8);
        chk("strap mode", 8'h01, {7'h00, m18});
        chk("strap gpio", 8'hFA, {coe, clo});
    endtask
    initial begin
        ph = 3'h0;
        {rst_n, wr_s, rd_s, run, dat, dtb} = 6'h01;
        {addr, wdat, fwd, pin, vid} = 28'h0000000;
        {strap, wck} = 2'h0;
        error_cnt = 0;
        comparisons = 0;
        tick(2);
        rst_n = 1'b1;
        s_regs;
        s_mclk;
        s_data;
        s_gpio;
        s_strap;
        complete_run;
    end
endmodule
